// File: pkg/pmr_defs.vh
// Purpose: Register map, field positions and reset values of the result store
// Assumes: Register address is the printed index; one register per index
// Notes:   Control and count registers beyond the result banks sit at chosen indexes
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH

// Printed result bank bases, one index per channel
`define PMR_ADDR_ACC_BASE     8'h03
`define PMR_ADDR_BUS_VOLTAGE_BASE    8'h07
`define PMR_ADDR_VSNS_BASE    8'h0B
`define PMR_ADDR_VAVG_BASE    8'h0F
// Accumulation counter, block controls and power result bank base
`define PMR_ADDR_ACCUMULATION_COUNTER    8'h02
`define PMR_ADDR_CTRL         8'h20
`define PMR_ADDR_POWER_BASE   8'h17

`define PMR_ADDR_W            8
`define PMR_DATA_W            56
`define PMR_RES_W             16
`define PMR_FINE_W            18
`define PMR_POWER_W           30
`define PMR_ACC_W             56
`define PMR_CNT_W             32
`define PMR_AVG_DEPTH         8
`define PMR_AVG_SHIFT         3

// Control register fields
`define PMR_CTRL_BUS_VOLTAGE_BIP     0
`define PMR_CTRL_VSNS_BIP     1
`define PMR_CTRL_ACC_SEL_LO   2
`define PMR_CTRL_ACC_SEL_HI   3
`define PMR_CTRL_W            4
`define PMR_CTRL_RESET        4'h0

// Accumulator source selection
`define PMR_ACC_SEL_POWER     2'h0
`define PMR_ACC_SEL_SENSE     2'h1
`define PMR_ACC_SEL_BUS       2'h2

`endif

// File: src/pmr_avg8.v
// Purpose: Rolling mean of the last eight bus-voltage results of one channel
// Assumes: Sample strobe is one cycle wide, bip selects two's complement
// Notes:   History lives in a small register memory; mean comes out of a flip-flop
`timescale 1ns/1ps
`include "pmr_defs.vh"

module pmr_avg8 #(
   parameter W     = 16,
   parameter DEPTH = 8,
   parameter SHIFT = 3
) (
   // Clock and reset
   input  wire           core_clk,
   input  wire           rstn,
   // New sample
   input  wire           smp_vld,
   input  wire [W-1:0]   smp_data,
   input  wire           bip,
   // Mean
   output reg  [W-1:0]   avg_ff
);

   ////////////////////////////////////////////////////////////////////////////
   reg  [W-1:0]       hist_ff [0:DEPTH-1];
   reg  [SHIFT-1:0]   wr_ptr_ff;
   reg  [W+SHIFT-1:0] nxt_sum;
   reg  [W-1:0]       cur;
   integer            i;
   integer            j;

   // Sum is rebuilt from the whole history with the present format, so a
   // range change never leaves a stale extension inside a running total
   always @* begin
      cur     = {W{1'b0}};
      nxt_sum = {(W+SHIFT){1'b0}};
      for (j = 0; j < DEPTH; j = j + 1) begin
         cur     = (j == wr_ptr_ff) ? smp_data : hist_ff[j];
         nxt_sum = nxt_sum + (bip ? {{SHIFT{cur[W-1]}}, cur} : {{SHIFT{1'b0}}, cur});
      end
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            hist_ff[i] <= {W{1'b0}};
         end
         wr_ptr_ff <= {SHIFT{1'b0}};
         avg_ff    <= {W{1'b0}};
      end else if (smp_vld) begin
         hist_ff[wr_ptr_ff] <= smp_data;
         wr_ptr_ff          <= wr_ptr_ff + 1'b1;
         // Empty slots count as zero until eight samples have arrived
         avg_ff             <= nxt_sum[W+SHIFT-1:SHIFT];
      end
   end

endmodule // pmr_avg8

// File: src/pmr_result_regs.v
// Purpose: Per-channel result store of a multi-channel power monitor
// Assumes: Conversion datapath gives one strobe per channel with fine operands
// Notes:   Registers are read-only except the control register
//
// What this block does
// - Accumulator is 56 bits, unsigned while both inputs are unipolar.
// - With either input bipolar when summing power, or the selected input bipolar, accumulator is 55 bits plus sign.
// - Accumulator sums power by default, or sense or bus samples when selected.
// - Power uses signed operands; reported unsigned only when both unipolar.
// - Multiply and accumulate use wider internal operands than 16-bit results.
// - Bus result is latest 16-bit value, two's complement when bipolar.
// - Sense result is latest 16-bit value, two's complement when bipolar.
// - Each channel keeps an eight-sample rolling bus mean, same format.
// - Result register set is replicated for one to four channels.
// - Power product is 30 bits unsigned, or 29 plus sign when bipolar.
// - A 32-bit counter increments each time results are accumulated.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "pmr_defs.vh"

module pmr_result_regs #(
   parameter NCH    = 4,
   parameter RES_W  = `PMR_RES_W,
   parameter FINE_W = `PMR_FINE_W,
   parameter PWR_W  = `PMR_POWER_W,
   parameter ACC_W  = `PMR_ACC_W,
   parameter CNT_W  = `PMR_CNT_W
) (
   // Clock and reset
   input  wire                    core_clk,
   input  wire                    rstn,
   // Conversion results, one strobe per channel
   input  wire [NCH-1:0]          conv_done,
   input  wire [NCH*FINE_W-1:0]   conv_bus_fine,
   input  wire [NCH*FINE_W-1:0]   conv_sense_fine,
   // Register port
   input  wire [`PMR_ADDR_W-1:0]  reg_addr,
   input  wire [`PMR_DATA_W-1:0]  reg_wdata,
   input  wire                    reg_wr,
   input  wire                    reg_rd,
   output reg  [`PMR_DATA_W-1:0]  reg_rdata_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   reg  [`PMR_CTRL_W-1:0] ctrl_ff;
   wire                   bus_voltage_bip;
   wire                   vsns_bip;
   wire                   any_bip;
   wire [1:0]             acc_sel;

   assign bus_voltage_bip = ctrl_ff[`PMR_CTRL_BUS_VOLTAGE_BIP];
   assign vsns_bip = ctrl_ff[`PMR_CTRL_VSNS_BIP];
   assign any_bip  = bus_voltage_bip | vsns_bip;
   assign acc_sel  = ctrl_ff[`PMR_CTRL_ACC_SEL_HI:`PMR_CTRL_ACC_SEL_LO];

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= `PMR_CTRL_RESET;
      end else if (reg_wr && reg_addr == `PMR_ADDR_CTRL) begin
         ctrl_ff <= reg_wdata[`PMR_CTRL_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel results
   wire [NCH*RES_W-1:0] bus_voltage_all;
   wire [NCH*RES_W-1:0] vsns_all;
   wire [NCH*RES_W-1:0] vavg_all;
   wire [NCH*PWR_W-1:0] pwr_all;
   wire [NCH*ACC_W-1:0] acc_all;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         wire [FINE_W-1:0]   bus_fine;
         wire [FINE_W-1:0]   sns_fine;
         wire [RES_W-1:0]    bus_res;
         wire [RES_W-1:0]    sns_res;
         wire [2*FINE_W-1:0] prod_full;
         wire [PWR_W-1:0]    nxt_pwr;
         reg  [ACC_W-1:0]    add_val;
         reg  [RES_W-1:0]    bus_voltage_ff;
         reg  [RES_W-1:0]    vsns_ff;
         reg  [PWR_W-1:0]    pwr_ff;
         reg  [ACC_W-1:0]    acc_ff;

         assign bus_fine = conv_bus_fine[g*FINE_W +: FINE_W];
         assign sns_fine = conv_sense_fine[g*FINE_W +: FINE_W];
         // Reported results keep the top bits of the fine operands
         assign bus_res  = bus_fine[FINE_W-1 -: RES_W];
         assign sns_res  = sns_fine[FINE_W-1 -: RES_W];

         // Operands are always signed; the unipolar fine value is positive
         // by construction, so the top product bits carry no information
         assign prod_full = $signed(bus_fine) * $signed(sns_fine);
         // Top 30 bits below the redundant sign of the signed product
         assign nxt_pwr = prod_full[2*FINE_W-2 -: PWR_W];

         // Accumulator addend, extended according to the format
         always @* begin
            case (acc_sel)
               `PMR_ACC_SEL_SENSE: add_val = vsns_bip
                  ? {{(ACC_W-FINE_W){sns_fine[FINE_W-1]}}, sns_fine}
                  : {{(ACC_W-FINE_W){1'b0}}, sns_fine};
               `PMR_ACC_SEL_BUS: add_val = bus_voltage_bip
                  ? {{(ACC_W-FINE_W){bus_fine[FINE_W-1]}}, bus_fine}
                  : {{(ACC_W-FINE_W){1'b0}}, bus_fine};
               default: add_val = any_bip
                  ? {{(ACC_W-PWR_W){nxt_pwr[PWR_W-1]}}, nxt_pwr}
                  : {{(ACC_W-PWR_W){1'b0}}, nxt_pwr};
            endcase
         end

         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               bus_voltage_ff <= {RES_W{1'b0}};
               vsns_ff <= {RES_W{1'b0}};
               pwr_ff  <= {PWR_W{1'b0}};
               acc_ff  <= {ACC_W{1'b0}};
            end else if (conv_done[g]) begin
               bus_voltage_ff <= bus_res;
               vsns_ff <= sns_res;
               pwr_ff  <= nxt_pwr;
               acc_ff  <= acc_ff + add_val;
            end
         end

         pmr_avg8 #(
            .W     (RES_W),
            .DEPTH (`PMR_AVG_DEPTH),
            .SHIFT (`PMR_AVG_SHIFT)
         ) u_avg (
            .core_clk (core_clk),
            .rstn     (rstn),
            .smp_vld  (conv_done[g]),
            .smp_data (bus_res),
            .bip      (bus_voltage_bip),
            .avg_ff   (vavg_all[g*RES_W +: RES_W])
         );

         assign bus_voltage_all[g*RES_W +: RES_W] = bus_voltage_ff;
         assign vsns_all[g*RES_W +: RES_W] = vsns_ff;
         assign pwr_all[g*PWR_W +: PWR_W]  = pwr_ff;
         assign acc_all[g*ACC_W +: ACC_W]  = acc_ff;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Accumulation counter
   reg [CNT_W-1:0] acc_cnt_ff;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_cnt_ff <= {CNT_W{1'b0}};
      end else if (|conv_done) begin
         // One count per accumulation event, even if channels finish together
         acc_cnt_ff <= acc_cnt_ff + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode
   reg [`PMR_DATA_W-1:0] nxt_rdata;
   integer               k;

   always @* begin
      nxt_rdata = {`PMR_DATA_W{1'b0}};
      if (reg_addr == `PMR_ADDR_ACCUMULATION_COUNTER) begin
         nxt_rdata[CNT_W-1:0] = acc_cnt_ff;
      end
      if (reg_addr == `PMR_ADDR_CTRL) begin
         nxt_rdata[`PMR_CTRL_W-1:0] = ctrl_ff;
      end
      for (k = 0; k < NCH; k = k + 1) begin
         if (reg_addr == `PMR_ADDR_ACC_BASE + k[`PMR_ADDR_W-1:0]) begin
            nxt_rdata[ACC_W-1:0] = acc_all[k*ACC_W +: ACC_W];
         end
         if (reg_addr == `PMR_ADDR_BUS_VOLTAGE_BASE + k[`PMR_ADDR_W-1:0]) begin
            nxt_rdata[RES_W-1:0] = bus_voltage_all[k*RES_W +: RES_W];
         end
         if (reg_addr == `PMR_ADDR_VSNS_BASE + k[`PMR_ADDR_W-1:0]) begin
            nxt_rdata[RES_W-1:0] = vsns_all[k*RES_W +: RES_W];
         end
         if (reg_addr == `PMR_ADDR_VAVG_BASE + k[`PMR_ADDR_W-1:0]) begin
            nxt_rdata[RES_W-1:0] = vavg_all[k*RES_W +: RES_W];
         end
         // Power sits in bits 31:2, low two bits read zero
         if (reg_addr == `PMR_ADDR_POWER_BASE + k[`PMR_ADDR_W-1:0]) begin
            nxt_rdata[PWR_W+1:2] = pwr_all[k*PWR_W +: PWR_W];
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata_ff <= {`PMR_DATA_W{1'b0}};
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= {`PMR_DATA_W{1'b0}};
      end
   end

endmodule // pmr_result_regs

// File: tb/pmr_result_regs_checker.sv
// Purpose: Port checks of the result store
// Assumes: One clock domain, rstn asynchronous active low
// Notes:   Bound to every result store instance
`timescale 1ns/1ps
`include "pmr_defs.vh"
module pmr_result_regs_checker #(
   parameter NCH    = 4,
   parameter FINE_W = 18
) (
   // Clock and reset
   input wire                    core_clk,
   input wire                    rstn,
   // Conversion side
   input wire [NCH-1:0]          conv_done,
   input wire [NCH*FINE_W-1:0]   conv_bus_fine,
   input wire [NCH*FINE_W-1:0]   conv_sense_fine,
   // Register port
   input wire [`PMR_ADDR_W-1:0]  reg_addr,
   input wire [`PMR_DATA_W-1:0]  reg_wdata,
   input wire                    reg_wr,
   input wire                    reg_rd,
   input wire [`PMR_DATA_W-1:0]  reg_rdata_ff
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   reg seen_ff;
   always @(posedge core_clk or negedge rstn)
      if (!rstn) seen_ff <= 1'b0;
      else if (|conv_done) seen_ff <= 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   property p_idle; !reg_rd |=> reg_rdata_ff == 56'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle zero");
   property p_bus; reg_rd && reg_addr >= 8'h07 && reg_addr <= 8'h0A |=> reg_rdata_ff[55:16] == 40'h0; endproperty
   a_bus: assert property (p_bus) else $error("bus result too wide");
   property p_sns; reg_rd && reg_addr >= 8'h0B && reg_addr <= 8'h0E |=> reg_rdata_ff[55:16] == 40'h0; endproperty
   a_sns: assert property (p_sns) else $error("sense result too wide");
   property p_avg; reg_rd && reg_addr >= 8'h0F && reg_addr <= 8'h12 |=> reg_rdata_ff[55:16] == 40'h0; endproperty
   a_avg: assert property (p_avg) else $error("average too wide");
   property p_pwr; reg_rd && reg_addr >= 8'h17 && reg_addr <= 8'h1A
      |=> reg_rdata_ff[55:32] == 24'h0 && reg_rdata_ff[1:0] == 2'h0; endproperty
   a_pwr: assert property (p_pwr) else $error("power field misplaced");
   property p_cnt; reg_rd && reg_addr == 8'h02 |=> reg_rdata_ff[55:32] == 24'h0; endproperty
   a_cnt: assert property (p_cnt) else $error("counter too wide");
   property p_clr; reg_rd && !seen_ff && reg_addr <= 8'h1A |=> reg_rdata_ff == 56'h0; endproperty
   a_clr: assert property (p_clr) else $error("result not zero after reset");
   property p_unm; reg_rd && reg_addr >= 8'h1B && reg_addr != 8'h20 |=> reg_rdata_ff == 56'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // pmr_result_regs_checker
bind pmr_result_regs pmr_result_regs_checker #(.NCH(NCH), .FINE_W(FINE_W)) u_chk (
   .core_clk(core_clk), .rstn(rstn), .conv_done(conv_done), .conv_bus_fine(conv_bus_fine),
   .conv_sense_fine(conv_sense_fine), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));

// File: tb/pmr_conv_src.sv
// Purpose: Conversion datapath model feeding the result store
// Assumes: One strobe cycle per request, unipolar values keep the top bit clear
// Notes:   Fine data is not held after the strobe
`timescale 1ns/1ps
module pmr_conv_src (
   // Clock
   input  wire        core_clk,
   // Requests and ranges
   input  wire [3:0]  req,
   input  wire        bus_bip,
   input  wire        sense_bip,
   // Results
   output reg  [3:0]  conv_done_ff,
   output reg  [71:0] bus_fine_ff,
   output reg  [71:0] sense_fine_ff
);
   integer g;
   function [17:0] pick(input bip);
      reg [31:0] r;
      begin
         r = $urandom;
         if (r[31:29] == 3'h0)
            pick = bip ? 18'h20000 : 18'h1FFFF;
         else
            pick = bip ? r[17:0] : {1'b0, r[16:0]};
      end
   endfunction
   initial begin
      conv_done_ff = 4'h0;
      bus_fine_ff = 72'h0;
      sense_fine_ff = 72'h0;
   end
   // Inverting idle data so a stale value never passes for a fresh one
   always @(posedge core_clk) begin
      conv_done_ff <= req;
      for (g = 0; g < 4; g = g + 1)
         if (req[g]) begin
            bus_fine_ff[g*18+:18] <= pick(bus_bip);
            sense_fine_ff[g*18+:18] <= pick(sense_bip);
         end else begin
            bus_fine_ff[g*18+:18] <= ~bus_fine_ff[g*18+:18];
            sense_fine_ff[g*18+:18] <= ~sense_fine_ff[g*18+:18];
         end
   end
endmodule // pmr_conv_src

// File: tb/pmr_result_regs_bench.sv
// Purpose: Self-checking bench of the result store
// Assumes: Four channels, reads answer one cycle after the strobe
// Notes:   Eight control modes, random channel masks
`timescale 1ns/1ps
module pmr_result_regs_bench;
   reg         core_clk, rstn, reg_wr, reg_rd;
   reg  [3:0]  req, ctrl, m;
   reg  [7:0]  reg_addr;
   reg  [55:0] reg_wdata, d;
   reg  [55:0] acc [0:3];
   reg  [15:0] hist [0:3][0:7];
   reg  [15:0] av [0:3];
   reg  [71:0] bf, sf;
   reg  [31:0] cnt, modes;
   reg  [17:0] b, s;
   reg  [35:0] p;
   wire [3:0]  conv_done;
   wire [71:0] bus_f, sns_f;
   wire [55:0] reg_rdata_ff;
   integer     mismatches, check_count, cycles, g, i, k, t;
   pmr_conv_src u_src (.core_clk(core_clk), .req(req), .bus_bip(ctrl[0]), .sense_bip(ctrl[1]),
      .conv_done_ff(conv_done), .bus_fine_ff(bus_f), .sense_fine_ff(sns_f));
   pmr_result_regs #(.NCH(4)) DUT (.core_clk(core_clk), .rstn(rstn), .conv_done(conv_done),
      .conv_bus_fine(bus_f), .conv_sense_fine(sns_f), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));
   ////////////////////////////////////////////////////////////////////////////////
   function [55:0] ext(input [17:0] v, input sg);
      ext = sg ? {{38{v[17]}}, v} : {38'h0, v};
   endfunction
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task rc(input [7:0] a, input [55:0] exp);
      begin
         @(posedge core_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         #1 check_count = check_count + 1;
         if (reg_rdata_ff !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: addr %h got %h exp %h", $time, a, reg_rdata_ff, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [55:0] v);
      begin
         @(posedge core_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge core_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task upd(input integer c);
      begin
         b = bf[c*18+:18];
         s = sf[c*18+:18];
         p = $signed(b) * $signed(s);
         for (k = 7; k > 0; k = k - 1)
            hist[c][k] = hist[c][k-1];
         hist[c][0] = b[17:2];
         case (ctrl[3:2])
            2'h1: acc[c] = acc[c] + ext(s, ctrl[1]);
            2'h2: acc[c] = acc[c] + ext(b, ctrl[0]);
            default: acc[c] = acc[c] + ((|ctrl[1:0]) ? {{26{p[34]}}, p[34:5]} : {26'h0, p[34:5]});
         endcase
         t = 0;
         for (k = 0; k < 8; k = k + 1)
            t = t + (ctrl[0] ? {{16{hist[c][k][15]}}, hist[c][k]} : {16'h0, hist[c][k]});
         av[c] = t >>> 3;
         rc(8'h07 + c, {40'h0, b[17:2]});
         rc(8'h0B + c, {40'h0, s[17:2]});
         rc(8'h0F + c, {40'h0, av[c]});
         rc(8'h17 + c, {24'h0, p[34:5], 2'h0});
         rc(8'h03 + c, acc[c]);
      end
   endtask
   task conv(input [3:0] mk);
      begin
         @(posedge core_clk);
         req <= mk;
         @(posedge core_clk);
         req <= 4'h0;
         #1 cnt = cnt + 1;
         bf = bus_f;
         sf = sns_f;
         for (g = 0; g < 4; g = g + 1)
            if (mk[g]) upd(g);
         rc(8'h02, {24'h0, cnt});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         test_done;
      end
   end
   initial begin
      {rstn, reg_wr, reg_rd, req, ctrl, reg_addr, reg_wdata} = 0;
      {mismatches, check_count, cycles, cnt} = 0;
      modes = 32'h7C843210;
      for (i = 0; i < 4; i = i + 1) begin
         acc[i] = 56'h0;
         for (k = 0; k < 8; k = k + 1)
            hist[i][k] = 16'h0;
      end
      i = $urandom(98);
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      for (i = 2; i < 27; i = i + 1)
         rc(i, 56'h0);
      wr(8'h07, {56{1'b1}});
      wr(8'h02, {56{1'b1}});
      rc(8'h07, 56'h0);
      rc(8'h02, 56'h0);
      rc(8'h30, 56'h0);
      for (i = 0; i < 8; i = i + 1) begin
         ctrl = modes[i*4+:4];
         wr(8'h20, {52'h0, ctrl});
         repeat (8) begin
            m = $urandom;
            conv((m == 4'h0) ? 4'hF : m);
         end
      end
      test_done;
   end
endmodule // pmr_result_regs_bench
